// File: pms_pkg.sv
package pms_pkg;
	localparam int PMS_REF_CLK_HZ = 50_000_000;
	localparam int PMS_MDC_STD_HZ = 2_500_000;
	localparam int PMS_MDC_FAST_HZ = 25_000_000;
	localparam int PMS_MDC_HALF_CYC = PMS_REF_CLK_HZ / (2 * PMS_MDC_STD_HZ);
	localparam int PMS_PREAMBLE_LEN = 32;
	localparam int PMS_FRAME_LEN = 64;
	localparam int PMS_TA_IDX = 46;
	localparam int PMS_DATA_IDX = 48;
	localparam int PMS_HEAD_BITS = 13;
	localparam int PMS_DATA_BITS = 16;
	localparam logic [1:0] PMS_START = 2'h1;
	localparam logic [1:0] PMS_OP_READ = 2'h2;
	localparam logic [1:0] PMS_OP_WRITE = 2'h1;
	localparam logic [1:0] PMS_TA_WRITE = 2'h2;
	localparam logic [4:0] PMS_BCAST_ADDR = 5'h00;
	localparam logic [4:0] PMS_REG_COMMON_CTRL = 5'h10;
	localparam logic [4:0] PMS_REG_OUT_CTRL = 5'h11;
	localparam logic [4:0] PMS_REG_INT_ENABLE = 5'h1a;
	localparam logic [4:0] PMS_REG_INT_STATUS = 5'h1b;
	localparam logic [4:0] PMS_REG_CTRL = 5'h1f;
	localparam int PMS_BIT_BCAST_EN = 0;
	localparam int PMS_BIT_MDIO_PP = 0;
	localparam int PMS_BIT_INT_PP = 1;
	localparam int PMS_BIT_INT_POL_INV = 14;
	localparam int PMS_NUM_EVENTS = 14;
	localparam int PMS_NUM_SUMMARY = 2;
	localparam logic [4:0] PMS_AV_CMD = 5'h00;
	localparam logic [4:0] PMS_AV_WDATA = 5'h04;
	localparam logic [4:0] PMS_AV_RDATA = 5'h08;
	localparam logic [4:0] PMS_AV_STATUS = 5'h0c;
	localparam logic [4:0] PMS_AV_IRQ_STATUS = 5'h10;
	localparam logic [4:0] PMS_AV_IRQ_CLEAR = 5'h14;
	localparam logic [4:0] PMS_AV_IRQ_ENABLE = 5'h18;
	localparam int PMS_CMD_PHY_LSB = 0;
	localparam int PMS_CMD_REG_LSB = 5;
	localparam int PMS_CMD_READ_BIT = 10;
	typedef enum logic [1:0] {
		PMS_IDLE = 2'h0,
		PMS_HEAD = 2'h1,
		PMS_TURN = 2'h3,
		PMS_DATA = 2'h2
	} pms_state_type;
endpackage : pms_pkg

// File: pms_mdio_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pms_mdio_if;
	logic mdc;
	logic ctl_o;
	logic ctl_oe_n;
	logic dev_o;
	logic dev_oe_n;
	logic mdio;
	// Wired line with pull-up: any enabled low wins, otherwise an enabled high or the pull-up.
	assign mdio = !((!ctl_oe_n && !ctl_o) || (!dev_oe_n && !dev_o));
	modport device (input mdc, input mdio, output dev_o, output dev_oe_n);
	modport ctrl (output mdc, output ctl_o, output ctl_oe_n, input mdio);
endinterface : pms_mdio_if
`default_nettype wire

// File: pms_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pms_sync #(
	parameter int W = 1
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} pms_sync_type;
	pms_sync_type s_q, s_d;
	always_comb begin
		s_d.meta = d_i;
		s_d.sync = s_q.meta;
	end
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign q_o = s_q.sync;
endmodule : pms_sync
`default_nettype wire

// File: pms_device.sv
// Overview of operation
// (RL1) Read frame: device drives TA 0, sixteen bits
// (RL2) Write frame: preamble, 01, 01, addresses, 10, data
// (RL3) Answer only own strapped five-bit address
// (RL4) Register field selects one of 32 registers
// (RL5) Keep off buses carrying Clause 45 frames
// (RL6) Reset: open-drain data, clock at most 2.5MHz
// (RL7) Switch to push-pull before running faster
// (RL8) Broadcast enable also accepts address zero
// (RL9) Control bit: 0 open-drain, 1 push-pull
// (RL10) Status bits set regardless of enable bits
// (RL11) Interrupt active when enabled status bit set
// (RL12) Status clears on read; summaries follow sources
// (RL13) Interrupt driver selectable, open-drain by default
// (RL14) Polarity invert bit; open-drain forces active low
// (RL15) MSB first, sampled at rising clock edge
// (RL16) Line released on mismatch, writes, and idle
`timescale 1ns/1ps
`default_nettype none
module pms_device
	import pms_pkg::*;
#(
	parameter int NUM_EVENTS = pms_pkg::PMS_NUM_EVENTS
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	pms_mdio_if.device mdio,
	input wire logic [4:0] strap_device_address_i,
	input wire logic broadcast_default_strap_i,
	input wire logic [NUM_EVENTS-1:0] int_event_i,
	input wire logic [pms_pkg::PMS_NUM_SUMMARY-1:0] int_summary_i,
	output logic int_o,
	output logic int_oe_n_o
);
	import pms_pkg::*;

	typedef struct packed {
		logic [31:0][15:0] regs;
		logic strap_done;
		logic [1:0] strap_wait;
		logic [4:0] own_addr;
		pms_state_type state;
		logic [5:0] ones;
		logic [4:0] cnt;
		logic [11:0] head;
		logic [15:0] shift;
		logic [15:0] tx;
		logic [4:0] reg_addr;
		logic is_read;
		logic hit;
		logic drive;
		logic drive_val;
		logic mdc_prev;
		logic mdio_o;
		logic mdio_oe_n;
		logic int_o;
		logic int_oe_n;
	} pms_dev_state_type;

	pms_dev_state_type s_q, s_d;
	logic mdc_s;
	logic mdio_s;
	logic [4:0] strap_addr_s;
	logic bcast_strap_s;
	logic rise;
	logic [12:0] hdr;
	logic [1:0] op;
	logic [4:0] phy;
	logic [4:0] regf;
	logic [NUM_EVENTS-1:0] sticky_clr;
	logic [15:0] status_view;
	logic int_active;
	logic push_pull;
	logic int_pp;
	logic pol_inv;

	// The clock pin is sampled like data, so edges are seen two to three cycles late.
	// Straps are pins as well, so they pass the same two flops and are latched once settled.
	pms_sync #(
		.W(8)
	) u_sync (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.d_i({strap_device_address_i, broadcast_default_strap_i, mdio.mdc, mdio.mdio}),
		.q_o({strap_addr_s, bcast_strap_s, mdc_s, mdio_s})
	);

	assign rise = mdc_s && !s_q.mdc_prev; // [RL15]
	assign hdr = {s_q.head, mdio_s};
	assign op = hdr[11:10];
	assign phy = hdr[9:5];
	assign regf = hdr[4:0];
	assign push_pull = s_q.regs[PMS_REG_OUT_CTRL][PMS_BIT_MDIO_PP];
	assign int_pp = s_q.regs[PMS_REG_OUT_CTRL][PMS_BIT_INT_PP];
	assign pol_inv = s_q.regs[PMS_REG_CTRL][PMS_BIT_INT_POL_INV];
	// Summary bits are not stored; they mirror their sources directly.
	assign status_view = {int_summary_i,
		s_q.regs[PMS_REG_INT_STATUS][NUM_EVENTS-1:0]}; // [RL12]
	assign int_active = |(status_view & s_q.regs[PMS_REG_INT_ENABLE]); // [RL11]

	always_comb begin
		s_d = s_q;
		sticky_clr = '0;
		s_d.mdc_prev = mdc_s;
		s_d.strap_wait = {s_q.strap_wait[0], 1'b1};
		if (s_q.strap_wait[1] && !s_q.strap_done) begin
			s_d.strap_done = 1'b1;
			s_d.own_addr = strap_addr_s; // [RL3]
			s_d.regs[PMS_REG_COMMON_CTRL][PMS_BIT_BCAST_EN] = bcast_strap_s; // [RL8]
		end
		if (rise) begin
			case (s_q.state)
				PMS_IDLE: begin
					if (mdio_s) begin
						if (s_q.ones < 6'(PMS_PREAMBLE_LEN)) begin
							s_d.ones = s_q.ones + 6'h01;
						end
					end else if (s_q.ones == 6'(PMS_PREAMBLE_LEN)) begin
						s_d.state = PMS_HEAD;
						s_d.cnt = '0;
					end else begin
						s_d.ones = '0;
					end
				end
				PMS_HEAD: begin
					s_d.head = hdr[11:0];
					s_d.cnt = s_q.cnt + 5'h01;
					if (s_q.cnt == 5'(PMS_HEAD_BITS - 1)) begin
						s_d.cnt = '0;
						s_d.ones = '0;
						s_d.reg_addr = regf; // [RL4]
						s_d.is_read = (op == PMS_OP_READ);
						s_d.hit = (phy == s_q.own_addr) || ((phy == PMS_BCAST_ADDR)
							&& s_q.regs[PMS_REG_COMMON_CTRL][PMS_BIT_BCAST_EN]); // [RL3] [RL8]
						s_d.tx = (regf == PMS_REG_INT_STATUS) ? status_view : s_q.regs[regf];
						if (hdr[12] == PMS_START[0] && (op == PMS_OP_READ || op == PMS_OP_WRITE)) begin
							s_d.state = PMS_TURN;
						end else begin
							s_d.state = PMS_IDLE;
						end
					end
				end
				PMS_TURN: begin
					s_d.cnt = s_q.cnt + 5'h01;
					if (s_q.cnt == 5'h00) begin
						s_d.drive = s_q.is_read && s_q.hit; // [RL1] [RL16]
						s_d.drive_val = 1'b0;
					end else begin
						s_d.state = PMS_DATA;
						s_d.cnt = '0;
						s_d.drive_val = s_q.tx[15]; // [RL15]
						s_d.tx = {s_q.tx[14:0], 1'b0};
					end
				end
				PMS_DATA: begin
					s_d.shift = {s_q.shift[14:0], mdio_s};
					s_d.cnt = s_q.cnt + 5'h01;
					s_d.drive_val = s_q.tx[15];
					s_d.tx = {s_q.tx[14:0], 1'b0};
					if (s_q.cnt == 5'(PMS_DATA_BITS - 1)) begin
						s_d.state = PMS_IDLE;
						s_d.drive = 1'b0; // [RL16]
						s_d.cnt = '0;
						if (!s_q.is_read && s_q.hit && s_q.reg_addr != PMS_REG_INT_STATUS) begin
							s_d.regs[s_q.reg_addr] = {s_q.shift[14:0], mdio_s}; // [RL2]
						end
					end
				end
				default: begin
					s_d.state = PMS_IDLE;
					s_d.drive = 1'b0;
				end
			endcase
		end
		// The status word is captured on the same edge that clears it, so nothing is lost.
		if (rise && s_q.state == PMS_HEAD && s_q.cnt == 5'(PMS_HEAD_BITS - 1)
			&& op == PMS_OP_READ && s_d.hit && regf == PMS_REG_INT_STATUS) begin
			sticky_clr = '1; // [RL12]
		end
		// Events set their bits whatever the enables say, and a set beats a clear.
		s_d.regs[PMS_REG_INT_STATUS][NUM_EVENTS-1:0] =
			(s_q.regs[PMS_REG_INT_STATUS][NUM_EVENTS-1:0] & ~sticky_clr) | int_event_i; // [RL10]
		s_d.regs[PMS_REG_INT_STATUS][15:NUM_EVENTS] = '0;
		// Open-drain only pulls low, so a high is left to the pull-up.
		if (push_pull) begin
			s_d.mdio_oe_n = !s_d.drive; // [RL9]
			s_d.mdio_o = s_d.drive_val;
		end else begin
			s_d.mdio_oe_n = !(s_d.drive && !s_d.drive_val); // [RL6] [RL9]
			s_d.mdio_o = 1'b0;
		end
		if (int_pp) begin
			s_d.int_oe_n = 1'b0; // [RL13]
			s_d.int_o = pol_inv ? int_active : !int_active; // [RL14]
		end else begin
			s_d.int_oe_n = !int_active; // [RL13] [RL14]
			s_d.int_o = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
			s_q.state <= PMS_IDLE;
			s_q.mdio_oe_n <= 1'b1;
			s_q.int_oe_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign mdio.dev_o = s_q.mdio_o;
	assign mdio.dev_oe_n = s_q.mdio_oe_n;
	assign int_o = s_q.int_o;
	assign int_oe_n_o = s_q.int_oe_n;
endmodule : pms_device
`default_nettype wire

// File: pms_controller.sv
`timescale 1ns/1ps
`default_nettype none
module pms_controller
	import pms_pkg::*;
#(
	parameter int HALF_DIV = pms_pkg::PMS_MDC_HALF_CYC
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	pms_mdio_if.ctrl mdio,
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic irq_o
);
	import pms_pkg::*;

	typedef struct packed {
		logic busy;
		logic rd;
		logic mdc;
		logic [7:0] div;
		logic [5:0] idx;
		logic [63:0] frame;
		logic [15:0] rx;
		logic [15:0] rdata;
		logic [15:0] wdata;
		logic out;
		logic oe_n;
		logic irq_st;
		logic irq_en;
		logic ack;
		logic [31:0] readdata;
	} pms_ctl_state_type;

	pms_ctl_state_type s_q, s_d;
	logic mdio_s;
	logic req;
	logic acc;
	logic done;
	logic clr;
	logic [1:0] cmd_op;
	logic [1:0] cmd_ta;
	logic [15:0] cmd_data;

	pms_sync #(
		.W(1)
	) u_sync (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.d_i(mdio.mdio),
		.q_o(mdio_s)
	);

	assign req = avs_read_i || avs_write_i;
	assign acc = req && s_q.ack;
	assign avs_waitrequest_o = req && !s_q.ack;
	assign cmd_op = avs_writedata_i[PMS_CMD_READ_BIT] ? PMS_OP_READ : PMS_OP_WRITE;
	assign cmd_ta = avs_writedata_i[PMS_CMD_READ_BIT] ? 2'h3 : PMS_TA_WRITE;
	assign cmd_data = avs_writedata_i[PMS_CMD_READ_BIT] ? 16'hffff : s_q.wdata;

	always_comb begin
		s_d = s_q;
		done = 1'b0;
		clr = 1'b0;
		s_d.ack = req && !s_q.ack;
		if (req && !s_q.ack) begin
			case (avs_address_i)
				PMS_AV_RDATA: s_d.readdata = {16'h0000, s_q.rdata};
				PMS_AV_WDATA: s_d.readdata = {16'h0000, s_q.wdata};
				PMS_AV_STATUS: s_d.readdata = {31'h0, s_q.busy};
				PMS_AV_IRQ_STATUS: s_d.readdata = {31'h0, s_q.irq_st};
				PMS_AV_IRQ_ENABLE: s_d.readdata = {31'h0, s_q.irq_en};
				default: s_d.readdata = '0;
			endcase
		end
		if (s_q.busy) begin
			s_d.div = s_q.div + 8'h01;
			if (s_q.div == 8'(HALF_DIV - 1)) begin
				s_d.div = '0;
				s_d.mdc = !s_q.mdc;
				if (!s_q.mdc) begin
					// The device samples at this rise too; read data is taken here.
					if (s_q.idx >= 6'(PMS_DATA_IDX)) begin
						s_d.rx = {s_q.rx[14:0], mdio_s};
					end
				end else if (s_q.idx == 6'(PMS_FRAME_LEN - 1)) begin
					s_d.busy = 1'b0;
					s_d.oe_n = 1'b1;
					s_d.rdata = s_q.rx;
					done = 1'b1;
				end else begin
					s_d.idx = s_q.idx + 6'h01;
					s_d.out = s_q.frame[63];
					s_d.frame = {s_q.frame[62:0], 1'b0};
					// A read hands the line over at the turnaround and never takes it back.
					s_d.oe_n = s_q.rd && (s_d.idx >= 6'(PMS_TA_IDX)); // [RL1]
				end
			end
		end
		if (acc && avs_write_i) begin
			case (avs_address_i)
				PMS_AV_CMD: begin
					// A command while a frame runs is dropped; software polls busy first.
					if (!s_q.busy) begin
						s_d.busy = 1'b1;
						s_d.rd = avs_writedata_i[PMS_CMD_READ_BIT];
						s_d.idx = '0;
						s_d.div = '0;
						s_d.mdc = 1'b0;
						s_d.oe_n = 1'b0;
						s_d.out = 1'b1;
						s_d.frame = {31'h7fffffff, PMS_START, cmd_op,
							avs_writedata_i[PMS_CMD_PHY_LSB +: 5],
							avs_writedata_i[PMS_CMD_REG_LSB +: 5], cmd_ta, cmd_data, 1'b0}; // [RL2] [RL5] [RL15]
					end
				end
				PMS_AV_WDATA: s_d.wdata = avs_writedata_i[15:0];
				PMS_AV_IRQ_CLEAR: clr = avs_writedata_i[0];
				PMS_AV_IRQ_ENABLE: s_d.irq_en = avs_writedata_i[0];
				default: s_d.wdata = s_q.wdata;
			endcase
		end
		s_d.irq_st = (s_q.irq_st && !clr) || done;
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
			s_q.oe_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign mdio.mdc = s_q.mdc;
	assign mdio.ctl_o = s_q.out;
	assign mdio.ctl_oe_n = s_q.oe_n;
	assign avs_readdata_o = s_q.readdata;
	assign irq_o = s_q.irq_st && s_q.irq_en;
endmodule : pms_controller
`default_nettype wire

// File: pms_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pms_assertions (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic mdc_i,
	input wire logic ctl_data_i,
	input wire logic ctl_oe_n_i,
	input wire logic dev_data_i,
	input wire logic dev_oe_n_i,
	input wire logic mdio_i
);
	logic [4:0] still_q;
	logic [6:0] bit_q;
	logic [3:0] rise_q;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	// The bit index is rebuilt from the wire alone, so a quiet clock must mark each frame gap.
	// Once the rise of bit k is seen bit_q holds k, so at that rise it still shows k-1.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			still_q <= 5'h00;
			bit_q <= 7'h00;
			rise_q <= 4'hf;
		end else begin
			still_q <= $changed(mdc_i) ? 5'h00 : still_q + {4'h0, still_q != 5'h1f};
			bit_q <= (still_q > 5'h0b) ? 7'h00 : bit_q + {6'h0, $rose(mdc_i)};
			rise_q <= $rose(mdc_i) ? 4'h0 : rise_q + {3'h0, rise_q != 4'hf};
		end
	end
	sequence s_start;
		!mdio_i ##20 ($rose(mdc_i) && mdio_i);
	endsequence
	property p_half;
		$changed(mdc_i) |=> $stable(mdc_i)[*8] ##1 $stable(mdc_i);
	endproperty
	a_half: assert property (p_half) else $error("mdc too fast");
	property p_hold;
		$rose(mdc_i) |-> $stable(ctl_data_i) && $stable(ctl_oe_n_i);
	endproperty
	a_hold: assert property (p_hold) else $error("ctl data moved at rise");
	property p_late;
		$changed(dev_oe_n_i) || $changed(dev_data_i) |-> rise_q < 4'h6;
	endproperty
	a_late: assert property (p_late) else $error("dev moved late");
	property p_fight;
		!ctl_oe_n_i |-> dev_oe_n_i;
	endproperty
	a_fight: assert property (p_fight) else $error("both drive");
	property p_window;
		!dev_oe_n_i |-> bit_q >= 7'h2e && bit_q <= 7'h3f;
	endproperty
	a_window: assert property (p_window) else $error("dev drives off slot");
	property p_idle;
		still_q > 5'h0b |-> dev_oe_n_i;
	endproperty
	a_idle: assert property (p_idle) else $error("dev drives idle");
	property p_pre;
		$rose(mdc_i) && bit_q < 7'h1f |-> mdio_i;
	endproperty
	a_pre: assert property (p_pre) else $error("preamble bit low");
	property p_start;
		$rose(mdc_i) && bit_q == 7'h1f |-> s_start;
	endproperty
	a_start: assert property (p_start) else $error("bad start");
	property p_ta;
		$rose(mdc_i) && bit_q == 7'h2e && ctl_oe_n_i |-> !mdio_i;
	endproperty
	a_ta: assert property (p_ta) else $error("turnaround not 0");
	property p_ta_drv;
		$rose(mdc_i) && bit_q == 7'h2e && ctl_oe_n_i |-> !dev_oe_n_i && !dev_data_i;
	endproperty
	a_ta_drv: assert property (p_ta_drv) else $error("dev not driving turnaround 0");
endmodule : pms_assertions
`default_nettype wire

// File: pms_test.sv
`timescale 1ns/1ps
`default_nettype none
module pms_test;
	import pms_pkg::*;
	logic ref_clk_i, rst_n_i, rd, wr, iq, io, ion, wt;
	logic hi = 1'b0;
	logic [4:0] adr;
	logic [31:0] wd, rdat, x;
	logic [13:0] ev;
	logic [1:0] sm;
	int failures = 0;
	int n_checks = 0;
	int cyc = 0;
	pms_mdio_if bus();
	pms_controller i_pms_controller(.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .mdio(bus.ctrl),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wt), .irq_o(iq));
	pms_device i_pms_device(.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .mdio(bus.device),
		.strap_device_address_i(5'h05), .broadcast_default_strap_i(1'b0), .int_event_i(ev),
		.int_summary_i(sm), .int_o(io), .int_oe_n_o(ion));
	pms_assertions i_pms_assertions(.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .mdc_i(bus.mdc),
		.ctl_data_i(bus.ctl_o), .ctl_oe_n_i(bus.ctl_oe_n), .dev_data_i(bus.dev_o),
		.dev_oe_n_i(bus.dev_oe_n), .mdio_i(bus.mdio));
	initial begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end
	task automatic end_sim();
		if (failures == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	// Open-drain mode must never show the device driving a one.
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (!bus.dev_oe_n && bus.dev_o)
			hi <= 1'b1;
		if (cyc == 50000) begin
			failures++;
			end_sim();
		end
	end
	task automatic ck(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("unexpected %0t %h %h", $time, s, e);
		end
	endtask : ck
	// Waitrequest and read data are taken as they stand at the rising edge that ends the wait.
	task automatic av(input logic [4:0] a, input logic w, input logic [31:0] d);
		@(posedge ref_clk_i);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		do
			@(posedge ref_clk_i);
		while (wt !== 1'b0);
		x = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : av
	task automatic fr(input logic r, input logic [4:0] p, input logic [4:0] g,
		input logic [15:0] d);
		av(PMS_AV_WDATA, 1'b1, {16'h0000, d});
		av(PMS_AV_CMD, 1'b1, {21'h000000, r, g, p});
		do
			av(PMS_AV_STATUS, 1'b0, 32'h00000000);
		while (x[0] !== 1'b0);
		av(PMS_AV_RDATA, 1'b0, 32'h00000000);
	endtask : fr
	task automatic rdk(input logic [4:0] g, input logic [15:0] e);
		fr(1'b1, 5'h05, g, 16'h0000);
		ck(x, {16'h0000, e});
	endtask : rdk
	task automatic fl(input logic [2:0] e);
		@(negedge ref_clk_i);
		ck({29'h0, iq, ion, io}, {29'h0, e});
	endtask : fl
	task automatic pulse(input logic [13:0] e);
		@(posedge ref_clk_i);
		ev <= e;
		@(posedge ref_clk_i);
		ev <= 14'h0000;
	endtask : pulse
	initial begin
		{rd, wr} = 2'h0;
		adr = 5'h00;
		wd = 32'h0;
		ev = 14'h0000;
		sm = 2'h0;
		rst_n_i = 1'b0;
		repeat (8) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		av(5'h1c, 1'b0, 32'h0);
		ck(x, 32'h0);
		fl(3'h2);
		fr(1'b0, 5'h05, 5'h03, 16'ha5c3);
		av(PMS_AV_IRQ_STATUS, 1'b0, 32'h0);
		ck(x, 32'h1);
		av(PMS_AV_IRQ_ENABLE, 1'b1, 32'h1);
		fl(3'h6);
		av(PMS_AV_IRQ_CLEAR, 1'b1, 32'h1);
		fl(3'h2);
		av(PMS_AV_IRQ_ENABLE, 1'b0, 32'h0);
		ck(x, 32'h1);
		av(PMS_AV_IRQ_ENABLE, 1'b1, 32'h0);
		fr(1'b0, 5'h05, 5'h1e, 16'h5a3c);
		rdk(5'h03, 16'ha5c3);
		rdk(5'h1e, 16'h5a3c);
		fr(1'b0, 5'h06, 5'h03, 16'h0000);
		fr(1'b0, PMS_BCAST_ADDR, 5'h03, 16'h0000);
		rdk(5'h03, 16'ha5c3);
		rdk(PMS_REG_COMMON_CTRL, 16'h0000);
		fr(1'b0, 5'h05, PMS_REG_COMMON_CTRL, 16'h0001);
		fr(1'b0, PMS_BCAST_ADDR, 5'h03, 16'h1111);
		rdk(5'h03, 16'h1111);
		pulse(14'h0008);
		rdk(PMS_REG_INT_ENABLE, 16'h0000);
		fl(3'h2);
		rdk(PMS_REG_INT_STATUS, 16'h0008);
		rdk(PMS_REG_INT_STATUS, 16'h0000);
		fr(1'b0, 5'h05, PMS_REG_INT_ENABLE, 16'h0008);
		fr(1'b0, 5'h05, PMS_REG_CTRL, 16'h4000);
		pulse(14'h0008);
		rdk(PMS_REG_CTRL, 16'h4000);
		fl(3'h0);
		fr(1'b0, 5'h05, PMS_REG_OUT_CTRL, 16'h0002);
		fl(3'h1);
		fr(1'b0, 5'h05, PMS_REG_CTRL, 16'h0000);
		fl(3'h0);
		rdk(PMS_REG_INT_STATUS, 16'h0008);
		fl(3'h1);
		sm <= 2'h1;
		rdk(PMS_REG_INT_STATUS, 16'h4000);
		rdk(PMS_REG_INT_STATUS, 16'h4000);
		sm <= 2'h0;
		ck({31'h0, hi}, 32'h0);
		fr(1'b0, 5'h05, PMS_REG_OUT_CTRL, 16'h0003);
		rdk(PMS_REG_OUT_CTRL, 16'h0003);
		ck({31'h0, hi}, 32'h1);
		end_sim();
	end
endmodule : pms_test
`default_nettype wire
